/* File: core/sdma_pkg.sv */
// Behaviour
// - Six channels, each programmed and run on its own.
// - Register space and data RAM may both be source or destination.
// - RAM address outside upper/lower limits terminates the transaction and flags it.
// - Each channel moves bytes or words, chosen by its size bit.
// - After reset every channel moves words.
// - In byte moves the address low bit picks the byte lane.
// - Any selected interrupt source can trigger a channel.
// - A channel may be triggered by another channel's completion.
// - Single-shot: one transaction per trigger.
// - Continuous: one trigger runs the whole counted series back to back.
// - Repeated single-shot: one transaction per trigger until channel disabled.
// - Repeated continuous: one full series per trigger until channel disabled.
// - Optional reload of pointers and counter at completion; repeated modes always reload.
// - Pointers fixed or stepping up or down by the data size.
// - Indirect mode adds the peripheral's offset to the channel base.
// - Round-robin: lower channel wins first, then priority rotates upward.
// - Fixed: lowest numbered requesting channel wins, skipping the channel just serviced while another requests.
// - Fixed: the channel just serviced is not granted again immediately while another channel requests.
// - A continuous requester yields to the next pending lower priority channel.
// - Bus is released whenever the processor needs it.
// - Per channel 16-bit source, destination and counter, live and reloadable.
// - Half-way counter interrupt and software-requested transfers.
// - Transfer mode codes: 00 single, 01 repeated single, 10 continuous, 11 repeated.
// - Address mode codes: 00 fixed, 01 increment, 10 decrement, 11 indirect.
// - Clearing module enable aborts every active transfer.
// - Priority select bit: 1 round-robin, 0 fixed.
package sdma_pkg;
    localparam int N_CH = 6;
    localparam int N_IRQ = 64;
    localparam int N_TRIG = N_IRQ + N_CH;
    localparam logic [15:0] SFR_TOP = 16'h07ff;
    localparam logic [5:0] CH_ONE = 6'h01;
    // Word index: adr[7:5] block (0 module, n+1 channel n), adr[4:2] register
    localparam logic [2:0] BLK_MOD = 3'h0;
    localparam logic [2:0] REG_MCTRL = 3'h0;
    localparam logic [2:0] REG_UPPER = 3'h1;
    localparam logic [2:0] REG_LOWER = 3'h2;
    localparam logic [2:0] REG_CCTRL = 3'h0;
    localparam logic [2:0] REG_SRC = 3'h1;
    localparam logic [2:0] REG_DST = 3'h2;
    localparam logic [2:0] REG_CNT = 3'h3;
    localparam logic [2:0] REG_INT = 3'h4;
    localparam int BIT_EN = 15;
    localparam int BIT_PRS = 0;
    localparam int BIT_CHREQ = 8;
    localparam int BIT_RELOAD = 9;
    localparam int BIT_CONT = 3;
    localparam int BIT_REP = 2;
    localparam int BIT_SIZE = 1;
    localparam int BIT_CHEN = 0;
    localparam int BIT_HIGHIF = 7;
    localparam int BIT_LOWIF = 6;
    localparam int BIT_DONEIF = 5;
    localparam int BIT_HALFIF = 4;
    localparam int BIT_OVRUNIF = 3;
    localparam int BIT_HALFEN = 0;
    localparam logic [15:0] CCTRL_WMASK = 16'h07ff;
    localparam logic [15:0] INT_WMASK = 16'h7ff9;
    localparam logic [15:0] INT_FLAGS = 16'h00f8;
    localparam logic [15:0] RST_CCTRL = 16'h0000;
    localparam logic [15:0] RST_UPPER = 16'hffff;
    localparam logic [15:0] RST_LOWER = 16'h0800;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [2:0] RST_LAST = 3'h5;
    typedef enum logic [1:0] {
        AM_FIXED = 2'b00,
        AM_INC = 2'b01,
        AM_DEC = 2'b10,
        AM_PIA = 2'b11
    } sdma_amode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } sdma_state_t;
endpackage

/* File: core/sdma_arb_if.sv */
`timescale 1ns/100ps
interface sdma_arb_if;
    logic [sdma_pkg::N_CH-1:0] req;
    logic roundRobin;
    logic take;
    logic [2:0] grantIdx;
    logic grantValid;
    modport ctl (output req, output roundRobin, output take, input grantIdx, input grantValid);
    modport arb (input req, input roundRobin, input take, output grantIdx, output grantValid);
endinterface

/* File: core/sdma_arbiter.sv */
`timescale 1ns/100ps
module sdma_arbiter (
    input wire logic ref_clk,
    input wire logic rst,
    sdma_arb_if.arb bus
);
    logic [2:0] last_r;
    logic [2:0] start;
    logic [sdma_pkg::N_CH-1:0] others;
    logic [sdma_pkg::N_CH-1:0] pool;
    logic [3:0] pick;

    // First requester at or after s, wrapping past the top channel
    function automatic logic [3:0] firstFrom(input logic [sdma_pkg::N_CH-1:0] r,
                                             input logic [2:0] s);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int k = sdma_pkg::N_CH - 1; k >= 0; k--) begin
            idx = 3'((int'(s) + k) % sdma_pkg::N_CH);
            if (r[idx]) begin
                res = {1'b1, idx};
            end
        end
        firstFrom = res;
    endfunction

    // Grant choice; in fixed mode last channel masked so a hog cannot starve others
    always_comb begin
        others = bus.req & ~(sdma_pkg::CH_ONE << last_r);
        pool = (others != '0) ? others : bus.req;
        start = (last_r == sdma_pkg::RST_LAST) ? 3'h0 : last_r + 3'h1;
        if (bus.roundRobin) begin
            pick = firstFrom(bus.req, start);
        end else begin
            pick = firstFrom(pool, 3'h0);
        end
    end

    assign bus.grantValid = pick[3];
    assign bus.grantIdx = pick[2:0];

    // Reset value makes channel 0 the first round-robin winner
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_r <= sdma_pkg::RST_LAST;
        end else if (bus.take) begin
            last_r <= bus.grantIdx;
        end
    end
endmodule

/* File: core/sdma_top.sv */
`timescale 1ns/100ps
module sdma_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [7:0] adr,
    input wire logic [3:0] sel,
    input wire logic [31:0] datWr,
    output logic [31:0] datRd,
    output logic ack,
    input wire logic [sdma_pkg::N_IRQ-1:0] irqSrc,
    input wire logic cpuBusy,
    input wire logic [15:0] piaOffset,
    output logic memReq,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [1:0] memBe,
    output logic [15:0] memWdata,
    input wire logic [15:0] memRdata,
    input wire logic memAck,
    output logic [sdma_pkg::N_CH-1:0] chanIrq,
    output logic [sdma_pkg::N_CH-1:0] chanDone
);
    localparam int NC = sdma_pkg::N_CH;

    logic ack_r;
    logic [31:0] datRd_r;
    logic en_r;
    logic prs_r;
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic [15:0] chCtrl_r [NC];
    logic [15:0] chInt_r [NC];
    logic [15:0] src_r [NC];
    logic [15:0] dst_r [NC];
    logic [15:0] cnt_r [NC];
    logic [15:0] srcSave_r [NC];
    logic [15:0] dstSave_r [NC];
    logic [15:0] cntSave_r [NC];
    logic [NC-1:0] pend_r;
    logic [NC-1:0] trigPrev_r;
    logic [NC-1:0] doneEvt_r;
    logic [NC-1:0] chanIrq_r;
    logic [NC-1:0] trigLvl;
    logic [NC-1:0] trig;
    logic [NC-1:0] chenVec;
    logic [sdma_pkg::N_TRIG-1:0] trigVec;
    sdma_pkg::sdma_state_t state_r;
    logic memReq_r;
    logic memWe_r;
    logic [15:0] memAddr_r;
    logic [15:0] memWdata_r;
    logic [1:0] memBe_r;
    logic [2:0] cur_r;
    logic [15:0] curDst_r;
    logic curByte_r;
    logic wbHit;
    logic wbWr;
    logic [2:0] blk;
    logic [2:0] regIdx;
    logic [2:0] rIdx;
    logic [15:0] wrData;
    logic [15:0] rdVal;
    logic [2:0] gCh;
    logic [15:0] gCtrl;
    logic [15:0] gSrc;
    logic [15:0] gDst;
    logic gBad;
    logic gHigh;
    logic start;
    logic finish;
    logic abort;
    logic [15:0] cCtrl;
    logic [15:0] cntN;
    logic lastTx;
    logic doReload;
    logic [7:0] rdByte;

    sdma_arb_if arbBus ();

    sdma_arbiter uArb (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(arbBus)
    );

    // Byte-lane merge of a 16-bit register write
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                            input logic [1:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Pointer step after a transaction
    function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] m,
                                             input logic byteSz);
        logic [15:0] d;
        d = byteSz ? 16'h0001 : 16'h0002;
        case (m)
            sdma_pkg::AM_INC: stepAddr = a + d;
            sdma_pkg::AM_DEC: stepAddr = a - d;
            default: stepAddr = a;
        endcase
    endfunction

    // Indirect mode: base plus peripheral offset
    function automatic logic [15:0] effAddr(input logic [15:0] a, input logic [1:0] m,
                                            input logic [15:0] ofs);
        effAddr = (m == sdma_pkg::AM_PIA) ? a + ofs : a;
    endfunction

    // Lanes used by one access
    function automatic logic [1:0] laneOf(input logic [15:0] a, input logic byteSz);
        laneOf = byteSz ? (a[0] ? 2'b10 : 2'b01) : 2'b11;
    endfunction

    // Only RAM above the register space is fenced
    function automatic logic beyond(input logic [15:0] a, input logic [15:0] hi,
                                    input logic [15:0] lo);
        beyond = (a > sdma_pkg::SFR_TOP) && ((a > hi) || (a < lo));
    endfunction

    assign datRd = datRd_r;
    assign ack = ack_r;
    assign memReq = memReq_r;
    assign memWe = memWe_r;
    assign memAddr = memAddr_r;
    assign memBe = memBe_r;
    assign memWdata = memWdata_r;
    assign chanIrq = chanIrq_r;
    assign chanDone = doneEvt_r;

    // Bus decode
    assign wbHit = cyc && stb && !ack_r;
    assign wbWr = cyc && stb && we && ack_r;
    assign blk = adr[7:5];
    assign regIdx = adr[4:2];
    assign rIdx = blk - 3'h1;
    assign wrData = datWr[15:0];

    // Trigger sources: interrupts, then every channel's completion
    assign trigVec = {doneEvt_r, irqSrc};

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : gTrig
            logic [6:0] selIdx;
            assign selIdx = chInt_r[g][14:8];
            assign trigLvl[g] = (selIdx < 7'(sdma_pkg::N_TRIG)) ? trigVec[selIdx] : 1'b0;
            assign trig[g] = trigLvl[g] && !trigPrev_r[g];
            assign chenVec[g] = chCtrl_r[g][sdma_pkg::BIT_CHEN];
        end
    endgenerate

    // Arbiter hookup; a new grant is taken only from idle
    assign arbBus.req = pend_r & chenVec;
    assign arbBus.roundRobin = prs_r;
    assign arbBus.take = start;

    // Granted channel's addresses and limit check
    always_comb begin
        gCh = arbBus.grantIdx;
        gCtrl = chCtrl_r[gCh];
        gSrc = effAddr(src_r[gCh], gCtrl[7:6], piaOffset);
        gDst = effAddr(dst_r[gCh], gCtrl[5:4], piaOffset);
        gBad = beyond(gSrc, upper_r, lower_r) || beyond(gDst, upper_r, lower_r);
        gHigh = (gSrc > upper_r) || (gDst > upper_r);
        start = (state_r == sdma_pkg::ST_IDLE) && en_r && arbBus.grantValid && !cpuBusy;
        abort = start && gBad;
        finish = (state_r == sdma_pkg::ST_WRITE) && memReq_r && memAck;
    end

    // Current channel's end-of-transaction view
    always_comb begin
        cCtrl = chCtrl_r[cur_r];
        cntN = cnt_r[cur_r] - 16'h0001;
        lastTx = (cntN == 16'h0000);
        doReload = cCtrl[sdma_pkg::BIT_REP] || cCtrl[sdma_pkg::BIT_RELOAD];
        rdByte = memAddr_r[0] ? memRdata[15:8] : memRdata[7:0];
    end

    // Register read mux; unmapped words read zero
    always_comb begin
        rdVal = 16'h0000;
        if (blk == sdma_pkg::BLK_MOD) begin
            case (regIdx)
                sdma_pkg::REG_MCTRL: rdVal = {en_r, 14'h0000, prs_r};
                sdma_pkg::REG_UPPER: rdVal = upper_r;
                sdma_pkg::REG_LOWER: rdVal = lower_r;
                default: rdVal = 16'h0000;
            endcase
        end else if (blk <= 3'(NC)) begin
            case (regIdx)
                sdma_pkg::REG_CCTRL: rdVal = chCtrl_r[rIdx];
                sdma_pkg::REG_SRC: rdVal = src_r[rIdx];
                sdma_pkg::REG_DST: rdVal = dst_r[rIdx];
                sdma_pkg::REG_CNT: rdVal = cnt_r[rIdx];
                sdma_pkg::REG_INT: rdVal = chInt_r[rIdx];
                default: rdVal = 16'h0000;
            endcase
        end
    end

    // Wishbone answer, one cycle after the request is seen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            datRd_r <= 32'h00000000;
        end else begin
            ack_r <= wbHit;
            if (wbHit) begin
                datRd_r <= {16'h0000, rdVal};
            end
        end
    end

    // Module control and RAM limits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_r <= 1'b0;
            prs_r <= 1'b0;
            upper_r <= sdma_pkg::RST_UPPER;
            lower_r <= sdma_pkg::RST_LOWER;
        end else if (wbWr && blk == sdma_pkg::BLK_MOD) begin
            case (regIdx)
                sdma_pkg::REG_MCTRL: begin
                    if (sel[1]) begin
                        en_r <= wrData[sdma_pkg::BIT_EN];
                    end
                    if (sel[0]) begin
                        prs_r <= wrData[sdma_pkg::BIT_PRS];
                    end
                end
                sdma_pkg::REG_UPPER: upper_r <= merge16(upper_r, wrData, sel[1:0]);
                sdma_pkg::REG_LOWER: lower_r <= merge16(lower_r, wrData, sel[1:0]);
                default: ;
            endcase
        end
    end

    // Transfer sequencer: read source word, then write destination
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= sdma_pkg::ST_IDLE;
            memReq_r <= 1'b0;
            memWe_r <= 1'b0;
            memAddr_r <= sdma_pkg::RST_ZERO;
            memBe_r <= 2'b00;
            memWdata_r <= sdma_pkg::RST_ZERO;
            cur_r <= 3'h0;
            curDst_r <= sdma_pkg::RST_ZERO;
            curByte_r <= 1'b0;
        end else if (!en_r) begin
            state_r <= sdma_pkg::ST_IDLE;
            memReq_r <= 1'b0;
            memWe_r <= 1'b0;
        end else begin
            unique case (state_r)
                sdma_pkg::ST_IDLE: begin
                    if (start && !gBad) begin
                        cur_r <= gCh;
                        curDst_r <= gDst;
                        curByte_r <= gCtrl[sdma_pkg::BIT_SIZE];
                        memAddr_r <= gSrc;
                        memBe_r <= laneOf(gSrc, gCtrl[sdma_pkg::BIT_SIZE]);
                        memWe_r <= 1'b0;
                        memReq_r <= 1'b1;
                        state_r <= sdma_pkg::ST_READ;
                    end
                end
                sdma_pkg::ST_READ: begin
                    if (memReq_r && memAck) begin
                        // Byte is copied to both lanes; the lane enable picks one
                        memWdata_r <= curByte_r ? {rdByte, rdByte} : memRdata;
                        memAddr_r <= curDst_r;
                        memBe_r <= laneOf(curDst_r, curByte_r);
                        memWe_r <= 1'b1;
                        memReq_r <= 1'b0;
                        state_r <= sdma_pkg::ST_WRITE;
                    end else begin
                        memReq_r <= !cpuBusy;
                    end
                end
                sdma_pkg::ST_WRITE: begin
                    if (finish) begin
                        memReq_r <= 1'b0;
                        memWe_r <= 1'b0;
                        state_r <= sdma_pkg::ST_IDLE;
                    end else begin
                        memReq_r <= !cpuBusy;
                    end
                end
                default: state_r <= sdma_pkg::ST_IDLE;
            endcase
        end
    end

    // Per-channel registers; hardware flag sets come last so they win
    always_ff @(posedge ref_clk) begin
        for (int c = 0; c < NC; c++) begin
            if (rst) begin
                chCtrl_r[c] <= sdma_pkg::RST_CCTRL;
                chInt_r[c] <= sdma_pkg::RST_ZERO;
                src_r[c] <= sdma_pkg::RST_ZERO;
                dst_r[c] <= sdma_pkg::RST_ZERO;
                cnt_r[c] <= sdma_pkg::RST_ZERO;
                srcSave_r[c] <= sdma_pkg::RST_ZERO;
                dstSave_r[c] <= sdma_pkg::RST_ZERO;
                cntSave_r[c] <= sdma_pkg::RST_ZERO;
                pend_r[c] <= 1'b0;
                trigPrev_r[c] <= 1'b0;
                doneEvt_r[c] <= 1'b0;
            end else begin
                doneEvt_r[c] <= 1'b0;
                trigPrev_r[c] <= trigLvl[c];
                // Pointer and counter update at the end of a transaction
                if (finish && cur_r == 3'(c)) begin
                    src_r[c] <= stepAddr(src_r[c], cCtrl[7:6], cCtrl[sdma_pkg::BIT_SIZE]);
                    dst_r[c] <= stepAddr(dst_r[c], cCtrl[5:4], cCtrl[sdma_pkg::BIT_SIZE]);
                    cnt_r[c] <= cntN;
                    if (lastTx) begin
                        chCtrl_r[c][sdma_pkg::BIT_CHREQ] <= 1'b0;
                        if (doReload) begin
                            src_r[c] <= srcSave_r[c];
                            dst_r[c] <= dstSave_r[c];
                            cnt_r[c] <= cntSave_r[c];
                        end
                        if (!cCtrl[sdma_pkg::BIT_REP]) begin
                            chCtrl_r[c][sdma_pkg::BIT_CHEN] <= 1'b0;
                        end
                    end
                end
                if (abort && gCh == 3'(c)) begin
                    chCtrl_r[c][sdma_pkg::BIT_CHEN] <= 1'b0;
                end
                // Software writes; a pointer write also sets its reload copy
                if (wbWr && blk == 3'(c + 1)) begin
                    case (regIdx)
                        sdma_pkg::REG_CCTRL:
                            chCtrl_r[c] <= merge16(chCtrl_r[c], wrData, sel[1:0])
                                & sdma_pkg::CCTRL_WMASK;
                        sdma_pkg::REG_SRC: begin
                            src_r[c] <= merge16(src_r[c], wrData, sel[1:0]);
                            srcSave_r[c] <= merge16(src_r[c], wrData, sel[1:0]);
                        end
                        sdma_pkg::REG_DST: begin
                            dst_r[c] <= merge16(dst_r[c], wrData, sel[1:0]);
                            dstSave_r[c] <= merge16(dst_r[c], wrData, sel[1:0]);
                        end
                        sdma_pkg::REG_CNT: begin
                            cnt_r[c] <= merge16(cnt_r[c], wrData, sel[1:0]);
                            cntSave_r[c] <= merge16(cnt_r[c], wrData, sel[1:0]);
                        end
                        // Flags clear on written 0, writing 1 leaves them
                        sdma_pkg::REG_INT:
                            chInt_r[c] <= (merge16(chInt_r[c], wrData, sel[1:0])
                                & sdma_pkg::INT_WMASK)
                                & (~sdma_pkg::INT_FLAGS | chInt_r[c]);
                        default: ;
                    endcase
                end
                // Pending request: clears first, then sets, so no trigger is lost
                if (!en_r) begin
                    pend_r[c] <= 1'b0;
                end else begin
                    if (finish && cur_r == 3'(c) && (lastTx || !cCtrl[sdma_pkg::BIT_CONT])) begin
                        pend_r[c] <= 1'b0;
                    end
                    if (abort && gCh == 3'(c)) begin
                        pend_r[c] <= 1'b0;
                    end
                    if (trig[c] && chCtrl_r[c][sdma_pkg::BIT_CHEN]) begin
                        pend_r[c] <= 1'b1;
                    end
                    if (wbWr && blk == 3'(c + 1) && regIdx == sdma_pkg::REG_CCTRL
                        && sel[1] && wrData[sdma_pkg::BIT_CHREQ]) begin
                        pend_r[c] <= 1'b1;
                    end
                end
                // Event flags
                if (trig[c] && chCtrl_r[c][sdma_pkg::BIT_CHEN] && pend_r[c]) begin
                    chInt_r[c][sdma_pkg::BIT_OVRUNIF] <= 1'b1;
                end
                if (abort && gCh == 3'(c)) begin
                    if (gHigh) begin
                        chInt_r[c][sdma_pkg::BIT_HIGHIF] <= 1'b1;
                    end else begin
                        chInt_r[c][sdma_pkg::BIT_LOWIF] <= 1'b1;
                    end
                end
                if (finish && cur_r == 3'(c)) begin
                    if (cntN == {1'b0, cntSave_r[c][15:1]}) begin
                        chInt_r[c][sdma_pkg::BIT_HALFIF] <= 1'b1;
                    end
                    if (lastTx) begin
                        chInt_r[c][sdma_pkg::BIT_DONEIF] <= 1'b1;
                        doneEvt_r[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Channel interrupt lines; half-way only when enabled
    always_ff @(posedge ref_clk) begin
        for (int c = 0; c < NC; c++) begin
            if (rst) begin
                chanIrq_r[c] <= 1'b0;
            end else begin
                chanIrq_r[c] <= chInt_r[c][sdma_pkg::BIT_HIGHIF]
                    || chInt_r[c][sdma_pkg::BIT_LOWIF]
                    || chInt_r[c][sdma_pkg::BIT_DONEIF]
                    || chInt_r[c][sdma_pkg::BIT_OVRUNIF]
                    || (chInt_r[c][sdma_pkg::BIT_HALFIF]
                        && chInt_r[c][sdma_pkg::BIT_HALFEN]);
            end
        end
    end
endmodule

/* File: verification/sdma_top_asserts.sv */
`timescale 1ns/100ps
module sdma_top_asserts (
    input wire logic ref_clk, rst, cyc, stb, ack, cpuBusy, memReq, memAck, memWe,
    input wire logic [15:0] memAddr,
    input wire logic [1:0] memBe,
    input wire logic [sdma_pkg::N_CH-1:0] chanDone
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_busRel; cpuBusy |=> !memReq; endproperty
    a_busRel: assert property (p_busRel) else $error("bus not released");
    property p_wbAns; cyc && stb && !ack |=> ack; endproperty
    a_wbAns: assert property (p_wbAns) else $error("no ack");
    property p_wbPulse; ack |=> !ack; endproperty
    a_wbPulse: assert property (p_wbPulse) else $error("ack too long");
    property p_hold; memReq && !memAck && !cpuBusy |=> memReq && $stable(memAddr); endproperty
    a_hold: assert property (p_hold) else $error("access changed");
    property p_drop; memReq && memAck |=> !memReq; endproperty
    a_drop: assert property (p_drop) else $error("access held");
    property p_doneCause; |chanDone |-> $past(memReq && memAck && memWe); endproperty
    a_doneCause: assert property (p_doneCause) else $error("done without write");
    property p_donePulse; |chanDone |=> chanDone == '0; endproperty
    a_donePulse: assert property (p_donePulse) else $error("done too long");
    property p_lane; memReq && memBe != 2'h3 |-> memBe == (memAddr[0] ? 2'h2 : 2'h1); endproperty
    a_lane: assert property (p_lane) else $error("wrong byte lane");
    // Main scenarios seen at least once
    c_done: cover property (|chanDone);
    c_stall: cover property (memReq ##1 cpuBusy);
    c_byte: cover property (memReq && memAck && memBe != 2'h3);
endmodule
bind sdma_top sdma_top_asserts u_sdma_top_asserts (.*);

/* File: verification/sdma_mem_model.sv */
`timescale 1ns/100ps
module sdma_mem_model (
    input wire logic ref_clk, memReq, memWe,
    input wire logic [15:0] memAddr, memWdata,
    input wire logic [1:0] memBe, lat,
    output logic [15:0] memRdata,
    output logic memAck
);
    logic [15:0] mem [0:32767];
    logic [1:0] waitCnt;
    initial {memAck, memRdata, waitCnt} = '0;
    // Lane writes at the taking edge; ack after lat wait cycles
    always @(posedge ref_clk) begin
        if (memReq && memAck && memWe && memBe[0]) mem[memAddr[15:1]][7:0] <= memWdata[7:0];
        if (memReq && memAck && memWe && memBe[1]) mem[memAddr[15:1]][15:8] <= memWdata[15:8];
        memAck <= memReq && !memAck && waitCnt == lat;
        waitCnt <= (memReq && !memAck && waitCnt != lat) ? waitCnt + 2'h1 : 2'h0;
        // Stale data is scrambled so a late sample cannot pass
        memRdata <= (memReq && !memAck && waitCnt == lat) ? mem[memAddr[15:1]] : ~memRdata;
    end
endmodule

/* File: verification/sdma_top_tb.sv */
`timescale 1ns/100ps
module sdma_top_tb;
    logic ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cpuBusy = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [31:0] datWr = 32'h0, datRd, rd;
    logic [63:0] irqSrc = 64'h0;
    logic [15:0] piaOffset = 16'h0, memAddr, memWdata, memRdata;
    logic ack, memReq, memWe, memAck;
    logic [1:0] memBe, lat = 2'h0;
    logic [5:0] chanIrq, chanDone;
    int n_mismatch = 0, checks = 0;
    sdma_top u_sdma_top (.*);
    sdma_mem_model u_sdma_mem_model (.*);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Classic cycle, held until ack is sampled
    task automatic wb(logic w, logic [7:0] a, logic [15:0] d);
        int t = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, datWr} <= {2'h3, w, a, 16'h0, d};
        do @(posedge ref_clk); while (ack !== 1'b1 && ++t < 20);
        if (ack !== 1'b1) n_mismatch++;
        rd = datRd;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic wait_done(int ch);
        int t = 0;
        while (chanDone[ch] !== 1'b1 && t++ < 300) @(posedge ref_clk);
        chk("done", 1, chanDone[ch]);
    endtask
    task automatic s_reset;
        wb(0, 8'h04, 0); chk("upper", 32'hffff, rd);
        wb(0, 8'h08, 0); chk("lower", 32'h0800, rd);
        wb(0, 8'h20, 0); chk("ctrl0", 32'h0, rd);
    endtask
    // Continuous word move, source up, destination down, CPU holding bus first
    task automatic s_cont;
        u_sdma_mem_model.mem[16'h0480] = 16'h1234;
        u_sdma_mem_model.mem[16'h0481] = 16'hbeef;
        wb(1, 8'h00, 16'h8000); wb(1, 8'h24, 16'h0900);
        wb(1, 8'h28, 16'h0a02); wb(1, 8'h2c, 16'h0002);
        cpuBusy <= 1'b1;
        wb(1, 8'h20, 16'h0169);
        repeat (4) @(posedge ref_clk);
        chk("busHeld", 0, memReq);
        cpuBusy <= 1'b0;
        wait_done(0);
        chk("dstHi", 32'h1234, u_sdma_mem_model.mem[16'h0501]);
        chk("dstLo", 32'hbeef, u_sdma_mem_model.mem[16'h0500]);
        wb(0, 8'h24, 0); chk("srcPtr", 32'h0904, rd);
    endtask
    // Byte single-shot on an interrupt source, slow memory
    task automatic s_byte;
        u_sdma_mem_model.mem[16'h0600] = 16'habcd;
        u_sdma_mem_model.mem[16'h0680] = 16'h5555;
        lat <= 2'h2;
        piaOffset <= 16'h0001;
        wb(1, 8'h44, 16'h0c00); wb(1, 8'h48, 16'h0d00);
        wb(1, 8'h4c, 16'h0001); wb(1, 8'h50, 16'h0500);
        wb(1, 8'h40, 16'h00c3);
        irqSrc[5] <= 1'b1;
        wait_done(1);
        chk("byteDst", 32'h55ab, u_sdma_mem_model.mem[16'h0680]);
        wb(0, 8'h44, 0); chk("piaBase", 32'h0c00, rd);
    endtask
    // Round-robin repeated one-shot, bus stolen mid-read
    task automatic s_rep;
        wb(1, 8'h00, 16'h8001); wb(0, 8'h00, 0); chk("mctrl", 32'h8001, rd);
        wb(1, 8'h84, 16'h0a00); wb(1, 8'h88, 16'h0b00);
        wb(1, 8'h8c, 16'h0001); wb(1, 8'h80, 16'h0145);
        @(posedge ref_clk) cpuBusy <= 1'b1;
        repeat (2) @(posedge ref_clk);
        cpuBusy <= 1'b0;
        wait_done(3);
        chk("repDst", 32'hbeef, u_sdma_mem_model.mem[16'h0580]);
        wb(0, 8'h84, 0); chk("repSrc", 32'h0a00, rd);
        wb(0, 8'h80, 0); chk("repCtrl", 32'h0045, rd);
    endtask
    task automatic s_limit;
        wb(1, 8'h04, 16'h0fff); wb(1, 8'h64, 16'h0900);
        wb(1, 8'h68, 16'h2000); wb(1, 8'h6c, 16'h0001);
        wb(1, 8'h60, 16'h0101);
        repeat (10) @(posedge ref_clk);
        chk("limIrq", 1, chanIrq[2]);
        wb(0, 8'h70, 0); chk("limFlag", 32'h0080, rd);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset; s_cont; s_byte; s_rep; s_limit;
        final_report;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        final_report;
    end
endmodule
